//--- shared/smbus_map.vh
// Offsets, field positions and reset values of the SMBus slave receiver.
// Assumes an APB slave with byte addresses on paddr[7:0].
`ifndef SMBUS_MAP_VH
`define SMBUS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_OWN_ADDR 8'h08
`define OFS_ADDR_MASK 8'h0c
`define OFS_DATA 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_CLEAR 8'h18
`define OFS_IRQ_ENABLE 8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_INHIBIT 0
`define CTL_HW_ACK 1
`define CTL_ACK_BIT 2
`define STA_ACK_REQ 0
`define STA_RX_ACTIVE 1
`define STA_TX_MODE 2
`define STA_BLOCKED 3
`define IRQ_ADDR 0
`define IRQ_DATA 1
`define IRQ_STOP 2

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define RST_CONTROL 3'h0
`define RST_OWN_ADDR 8'h00
`define RST_ADDR_MASK 8'hfe
`define RST_IRQ 3'h0
`define BYTE_BITS 4'h8

`endif

//--- src/bit_sync.v
// Two-flop synchroniser for one bus line.
// Assumes the line idles high, so reset loads a one.
`timescale 1ns/1ps

module bit_sync
(
    input wire pclk,
    input wire presetn,
    input wire line_in,
    output reg line_sync
);

reg stage_one;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        stage_one <= 1'b1;
        line_sync <= 1'b1;
    end
    else
    begin
        stage_one <= line_in;
        line_sync <= stage_one;
    end
end

endmodule // bit_sync

//--- src/bus_condition.v
// Edge, START and STOP detection on synchronised SCL and SDA.
// Assumes both inputs are already in the pclk domain.
`timescale 1ns/1ps

module bus_condition
(
    input wire pclk,
    input wire presetn,
    input wire scl_s,
    input wire sda_s,
    output reg scl_rise,
    output reg scl_fall,
    output reg start_det,
    output reg stop_det
);

reg scl_q;
reg sda_q;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        scl_q <= 1'b1;
        sda_q <= 1'b1;
        scl_rise <= 1'b0;
        scl_fall <= 1'b0;
        start_det <= 1'b0;
        stop_det <= 1'b0;
    end
    else
    begin
        scl_q <= scl_s;
        sda_q <= sda_s;
        scl_rise <= scl_s & ~scl_q;
        scl_fall <= ~scl_s & scl_q;
        // SDA moving while SCL stays high
        start_det <= scl_s & scl_q & sda_q & ~sda_s;
        stop_det <= scl_s & scl_q & ~sda_q & sda_s;
    end
end

endmodule // bus_condition

//--- src/smbus_slave_receiver.v
// SMBus slave receiver with APB registers and one level interrupt.
// Assumes open-drain pins resolved outside; SCL and SDA are asynchronous.
`timescale 1ns/1ps
`include "smbus_map.vh"

module smbus_slave_receiver
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg irq
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [5:0] ST_IDLE = 6'b00_0001;
localparam [5:0] ST_RECV = 6'b00_0010;
localparam [5:0] ST_WAIT_SW = 6'b00_0100;
localparam [5:0] ST_ACK = 6'b00_1000;
localparam [5:0] ST_SKIP = 6'b01_0000;
localparam [5:0] ST_TX = 6'b10_0000;

// ----------------------------------------
// Declarations
// ----------------------------------------
reg [2:0] control;
reg [7:0] own_slave_address_reg;
reg [7:0] slave_address_mask_reg;
reg [7:0] serial_data_reg;
reg [2:0] irq_status;
reg [2:0] irq_enable;
reg [2:0] irq_set;
reg [2:0] post_irq;
reg ack_request_flag;
reg event_block;
reg tx_mode;
reg rx_active;
reg addr_phase;
reg ack_drive;
reg [5:0] state;
reg [7:0] shift;
reg [3:0] bit_count;
wire [1:0] raw_lines;
wire [1:0] sync_lines;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire [32:0] read_word;

wire access = psel & penable & pready;
wire wr_en = access & pwrite;
wire wr_ctl = wr_en & (paddr == `OFS_CONTROL);
wire wr_dat = wr_en & (paddr == `OFS_DATA);
wire [2:0] irq_clr = (wr_en && paddr == `OFS_IRQ_CLEAR) ?
                     pwdata[2:0] : 3'h0;
wire slave_event_inhibit = control[`CTL_INHIBIT];
wire hw_ack = control[`CTL_HW_ACK];
wire ack_bit = control[`CTL_ACK_BIT];

// ----------------------------------------
// Functions
// ----------------------------------------
function addr_match;
    input [7:0] rx;
    input [7:0] own;
    input [7:0] mask;
    begin
        addr_match = (((rx ^ own) & mask & 8'hfe) == 8'h00);
    end
endfunction

// Bit 32 flags an unmapped offset
function [32:0] read_mux;
    input [7:0] addr;
    begin
        read_mux = 33'h0_0000_0000;
        case (addr)
            `OFS_CONTROL: read_mux[2:0] = control;
            `OFS_STATUS:
            begin
                read_mux[`STA_ACK_REQ] = ack_request_flag;
                read_mux[`STA_RX_ACTIVE] = rx_active;
                read_mux[`STA_TX_MODE] = tx_mode;
                read_mux[`STA_BLOCKED] = event_block;
            end
            `OFS_OWN_ADDR: read_mux[7:0] = own_slave_address_reg;
            `OFS_ADDR_MASK: read_mux[7:0] = slave_address_mask_reg;
            `OFS_DATA: read_mux[7:0] = serial_data_reg;
            `OFS_IRQ_STATUS: read_mux[2:0] = irq_status;
            `OFS_IRQ_CLEAR: read_mux = 33'h0_0000_0000;
            `OFS_IRQ_ENABLE: read_mux[2:0] = irq_enable;
            default: read_mux[32] = 1'b1;
        endcase
    end
endfunction

assign read_word = read_mux(paddr);
assign raw_lines = {scl_in, sda_in};

// ----------------------------------------
// Line synchronisers and conditions
// ----------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
        bit_sync u_sync
        (
            .pclk(pclk),
            .presetn(presetn),
            .line_in(raw_lines[gi]),
            .line_sync(sync_lines[gi])
        );
    end
endgenerate

bus_condition u_cond
(
    .pclk(pclk),
    .presetn(presetn),
    .scl_s(sync_lines[1]),
    .sda_s(sync_lines[0]),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
);

// ----------------------------------------
// APB slave
// ----------------------------------------
// Read data captured in setup; one wait-free access phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end
    else
    begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & read_word[32];
        prdata <= (psel && !penable && !pwrite) ?
                  read_word[31:0] : 32'h0000_0000;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        control <= `RST_CONTROL;
        own_slave_address_reg <= `RST_OWN_ADDR;
        slave_address_mask_reg <= `RST_ADDR_MASK;
        irq_enable <= `RST_IRQ;
    end
    else if (wr_en)
    begin
        case (paddr)
            `OFS_CONTROL: control <= pwdata[2:0];
            `OFS_OWN_ADDR: own_slave_address_reg <= pwdata[7:0];
            `OFS_ADDR_MASK: slave_address_mask_reg <= pwdata[7:0];
            `OFS_IRQ_ENABLE: irq_enable <= pwdata[2:0];
            default: control <= control;
        endcase
    end
end

// ----------------------------------------
// Interrupts
// ----------------------------------------
// Set wins over a clear in the same cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_status <= `RST_IRQ;
        irq <= 1'b0;
    end
    else
    begin
        irq_status <= (irq_status & ~irq_clr) | irq_set;
        irq <= |(irq_status & irq_enable);
    end
end

// ----------------------------------------
// Receiver state machine
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_IDLE;
        shift <= 8'h00;
        bit_count <= 4'h0;
        addr_phase <= 1'b0;
        ack_drive <= 1'b0;
        post_irq <= 3'h0;
        irq_set <= 3'h0;
        ack_request_flag <= 1'b0;
        event_block <= 1'b0;
        tx_mode <= 1'b0;
        rx_active <= 1'b0;
        serial_data_reg <= 8'h00;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        scl_out <= 1'b0;
        sda_out <= 1'b0;
    end
    else
    begin
        irq_set <= 3'h0;
        if (start_det)
        begin
            event_block <= 1'b0;
            state <= ST_RECV;
            bit_count <= 4'h0;
            addr_phase <= 1'b1;
            ack_request_flag <= 1'b0;
            rx_active <= 1'b0;
            tx_mode <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_det)
        begin
            if (rx_active && !event_block)
                irq_set[`IRQ_STOP] <= 1'b1;
            state <= ST_IDLE;
            rx_active <= 1'b0;
            tx_mode <= 1'b0;
            ack_request_flag <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (wr_dat && rx_active)
        begin
            state <= ST_TX;
            tx_mode <= 1'b1;
            rx_active <= 1'b0;
            ack_request_flag <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RECV:
                begin
                    // shift the address byte, then each data byte once the address is accepted
                    if (scl_rise)
                    begin
                        shift <= {shift[6:0], sync_lines[0]};
                        bit_count <= bit_count + 4'h1;
                    end
                    else if (scl_fall && bit_count == `BYTE_BITS)
                    begin
                        if (addr_phase)
                        begin
                            // write to a matching address only
                            if (slave_event_inhibit || shift[0] ||
                                !addr_match(shift, own_slave_address_reg,
                                            slave_address_mask_reg))
                            begin
                                event_block <= 1'b1;
                                state <= ST_SKIP;
                            end
                            else if (hw_ack)
                            begin
                                ack_drive <= 1'b1;
                                sda_oe <= 1'b1;
                                post_irq <= 3'h1 << `IRQ_ADDR;
                                state <= ST_ACK;
                            end
                            else
                            begin
                                ack_request_flag <= 1'b1;
                                irq_set[`IRQ_ADDR] <= 1'b1;
                                post_irq <= 3'h0;
                                scl_oe <= 1'b1;
                                state <= ST_WAIT_SW;
                            end
                        end
                        else
                        begin
                            serial_data_reg <= shift;
                            if (hw_ack)
                            begin
                                ack_drive <= ack_bit;
                                sda_oe <= ack_bit;
                                post_irq <= 3'h1 << `IRQ_DATA;
                                state <= ST_ACK;
                            end
                            else
                            begin
                                ack_request_flag <= 1'b1;
                                if (!event_block)
                                    irq_set[`IRQ_DATA] <= 1'b1;
                                post_irq <= 3'h0;
                                scl_oe <= 1'b1;
                                state <= ST_WAIT_SW;
                            end
                        end
                    end
                end
                ST_WAIT_SW:
                begin
                    if (wr_ctl)
                    begin
                        // ack pulls low, nack leaves it high
                        ack_request_flag <= 1'b0;
                        ack_drive <= pwdata[`CTL_ACK_BIT];
                        sda_oe <= pwdata[`CTL_ACK_BIT];
                        scl_oe <= 1'b0;
                        state <= ST_ACK;
                    end
                end
                ST_ACK:
                begin
                    // Ninth clock ends at its falling edge
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        bit_count <= 4'h0;
                        if (!event_block)
                            irq_set <= post_irq;
                        if (addr_phase && !ack_drive)
                        begin
                            event_block <= 1'b1;
                            state <= ST_SKIP;
                        end
                        else
                        begin
                            if (addr_phase)
                                rx_active <= 1'b1;
                            addr_phase <= 1'b0;
                            state <= ST_RECV;
                        end
                    end
                end
                ST_SKIP: state <= ST_SKIP;
                ST_TX: state <= ST_TX;
                ST_IDLE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end
end

endmodule // smbus_slave_receiver

//--- testbench/smbus_slave_receiver_chk.sv
// Checker on the ports of the SMBus slave receiver.
// Assumes one pclk domain; SCL and SDA inputs are the resolved wires.
`timescale 1ns/1ps

module smbus_slave_receiver_chk
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bus side
    // ----------------------------------------
    setup_then_ready_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_qualified_a: assert property (pslverr |-> pready && prdata == 0)
        else $error("pslverr without pready or with data");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside access");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq && !sda_oe && !scl_oe)
        else $error("outputs active after reset");
    // ----------------------------------------
    // Link side
    // ----------------------------------------
    pins_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin drives high");
    ack_in_low_a: assert property ($rose(sda_oe) |-> !$past(scl_in))
        else $error("ack driven while scl high");
    ack_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda changed while scl high");
    stretch_in_low_a: assert property ($rose(scl_oe) |-> !$past(scl_in))
        else $error("stretch started while scl high");
    hold_exclusive_a: assert property (!(sda_oe && scl_oe))
        else $error("ack and stretch together");
endmodule // smbus_slave_receiver_chk

bind smbus_slave_receiver smbus_slave_receiver_chk chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

//--- testbench/smbus_master_model.sv
// SMBus master writing to the slave receiver, SCL period 8 pclk.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps

module smbus_master_model
(
    input wire pclk,
    input wire scl_line,
    input wire sda_line,
    output reg scl_drv,
    output reg sda_drv
);
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task wt(input integer k);
        repeat (k) @(posedge pclk);
    endtask
    task start_cond;
        begin
            sda_drv <= 1'b1;
            scl_drv <= 1'b1;
            wt(3);
            sda_drv <= 1'b0;
            wt(3);
            scl_drv <= 1'b0;
        end
    endtask
    task stop_cond;
        begin
            wt(3);
            sda_drv <= 1'b0;
            wt(2);
            scl_drv <= 1'b1;
            wt(3);
            sda_drv <= 1'b1;
            // Lets the synchronised STOP land before the next access
            wt(6);
        end
    endtask
    // MSB first, ninth bit released; waits out a stretch
    task put_byte(input [7:0] b, output ack);
        integer i;
        integer n;
        begin
            for (i = 0; i < 9; i = i + 1)
            begin
                wt(3);
                sda_drv <= (i < 8) ? b[7 - i] : 1'b1;
                wt(2);
                scl_drv <= 1'b1;
                n = 0;
                @(posedge pclk);
                while (scl_line !== 1'b1 && n < 5000)
                begin
                    n = n + 1;
                    @(posedge pclk);
                end
                wt(2);
                ack = ~sda_line;
                scl_drv <= 1'b0;
            end
        end
    endtask
endmodule // smbus_master_model

//--- testbench/test_smbus_slave_receiver.sv
// Self-checking bench for the SMBus slave receiver over APB.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "smbus_map.vh"

module test_smbus_slave_receiver;
    reg pclk, presetn, psel, penable, pwrite;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
    wire scl_drv, sda_drv;
    // Pull-ups: a line is low while any party pulls it
    wire scl_line = scl_drv & ~scl_oe;
    wire sda_line = sda_drv & ~sda_oe;
    integer fails, cmp_count, seed, i, n;
    reg [31:0] r;
    reg err, ack, ok;
    reg [7:0] a, m, d;

    smbus_slave_receiver uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    smbus_master_model mst (.pclk(pclk), .scl_line(scl_line),
        .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));

    always #50 pclk = ~pclk;

    task chk(input [31:0] s, input [31:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e)
            begin
                fails = fails + 1;
                $display("[FAIL] %0t seen %h exp %h", $time, s, e);
            end
        end
    endtask
    task chk1(input s, input e);
        chk({31'h0000_0000, s}, {31'h0000_0000, e});
    endtask
    task report_and_stop;
        begin
            if (fails == 0 && cmp_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Holds the request until pready, then idles one cycle
    task apb(input w, input [7:0] ad, input [31:0] wd);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= ad;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50)
            begin
                n = n + 1;
                @(posedge pclk);
            end
            if (n == 50)
                fails = fails + 1;
            r = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rd(input [7:0] ad, input [7:0] e);
        begin
            apb(1'b0, ad, 32'h0000_0000);
            chk(r, {24'h00_0000, e});
        end
    endtask
    task wr(input [7:0] ad, input [7:0] v);
        apb(1'b1, ad, {24'h00_0000, v});
    endtask
    task wait_irq;
        begin
            n = 0;
            while (irq !== 1'b1 && n < 500)
            begin
                n = n + 1;
                @(posedge pclk);
            end
            if (n == 500)
                fails = fails + 1;
        end
    endtask
    // Masked compare against own address 0x5b on bits 7:1; bit 0 must be clear
    function exp_match(input [7:0] ad, input [7:0] mk);
        exp_match = (((ad ^ 8'h5b) & mk & 8'hfe) == 8'h00) && !ad[0];
    endfunction

    initial
    begin
        #2_000_000;
        fails = fails + 1;
        report_and_stop;
    end

    initial
    begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        fails = 0;
        cmp_count = 0;
        seed = 32'hc09a;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`OFS_CONTROL, 8'h00);
        rd(`OFS_ADDR_MASK, 8'hfe);
        rd(`OFS_IRQ_ENABLE, 8'h00);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk1(err, 1'b1);
        wr(`OFS_OWN_ADDR, 8'h5b);
        // Hardware ack, interrupt masked at first
        wr(`OFS_CONTROL, 8'h06);
        mst.start_cond;
        mst.put_byte(8'h5a, ack);
        chk1(ack, 1'b1);
        mst.wt(6);
        rd(`OFS_IRQ_STATUS, 8'h01);
        chk1(irq, 1'b0);
        wr(`OFS_IRQ_ENABLE, 8'h07);
        mst.wt(2);
        chk1(irq, 1'b1);
        wr(`OFS_IRQ_CLEAR, 8'h01);
        mst.wt(2);
        chk1(irq, 1'b0);
        for (i = 0; i < 3; i = i + 1)
        begin
            r = $random(seed);
            d = r[7:0];
            mst.put_byte(d, ack);
            chk1(ack, 1'b1);
            mst.wt(6);
            rd(`OFS_DATA, d);
            rd(`OFS_IRQ_STATUS, 8'h02);
            wr(`OFS_IRQ_CLEAR, 8'h02);
        end
        // Preset NACK before the byte comes
        wr(`OFS_CONTROL, 8'h02);
        mst.put_byte(8'hc3, ack);
        chk1(ack, 1'b0);
        rd(`OFS_STATUS, 8'h02);
        mst.stop_cond;
        rd(`OFS_STATUS, 8'h00);
        rd(`OFS_IRQ_STATUS, 8'h06);
        wr(`OFS_IRQ_CLEAR, 8'h07);
        // Address then STOP, no data at all
        wr(`OFS_CONTROL, 8'h06);
        mst.start_cond;
        mst.put_byte(8'h5a, ack);
        mst.stop_cond;
        rd(`OFS_IRQ_STATUS, 8'h05);
        // Random masks; even trials forced to match
        for (i = 0; i < 6; i = i + 1)
        begin
            r = $random(seed);
            m = r[7:0];
            a = r[15:8];
            a[0] = 1'b0;
            if (i % 2 == 0)
                a = (a & ~m) | (8'h5a & m);
            ok = exp_match(a, m);
            wr(`OFS_ADDR_MASK, m);
            wr(`OFS_IRQ_CLEAR, 8'h07);
            mst.start_cond;
            mst.put_byte(a, ack);
            chk1(ack, ok);
            mst.put_byte(8'h96, ack);
            chk1(ack, ok);
            mst.stop_cond;
            rd(`OFS_IRQ_STATUS, ok ? 8'h07 : 8'h00);
        end
        wr(`OFS_ADDR_MASK, 8'hfe);
        // Inhibit set, then read direction: both refused
        wr(`OFS_CONTROL, 8'h07);
        mst.start_cond;
        mst.put_byte(8'h5a, ack);
        chk1(ack, 1'b0);
        mst.stop_cond;
        wr(`OFS_CONTROL, 8'h06);
        mst.start_cond;
        mst.put_byte(8'h5b, ack);
        chk1(ack, 1'b0);
        mst.stop_cond;
        // Software ack: stretch, flag and interrupt before the ack
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_IRQ_CLEAR, 8'h07);
        mst.start_cond;
        fork
            mst.put_byte(8'h5a, ack);
            begin
                wait_irq;
                rd(`OFS_STATUS, 8'h01);
                rd(`OFS_IRQ_STATUS, 8'h01);
                wr(`OFS_IRQ_CLEAR, 8'h01);
                wr(`OFS_CONTROL, 8'h04);
            end
        join
        chk1(ack, 1'b1);
        r = $random(seed);
        d = r[7:0];
        fork
            mst.put_byte(d, ack);
            begin
                wait_irq;
                rd(`OFS_DATA, d);
                rd(`OFS_STATUS, 8'h03);
                wr(`OFS_IRQ_CLEAR, 8'h02);
                wr(`OFS_CONTROL, 8'h00);
            end
        join
        chk1(ack, 1'b0);
        wr(`OFS_DATA, 8'h3c);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk(r & 32'h0000_0004, 32'h0000_0004);
        mst.stop_cond;
        report_and_stop;
    end
endmodule // test_smbus_slave_receiver
